// ==== adc_ctrl.sv ====
// converter control: clock divider, timebase, reference, window compare, interrupts
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE_01] converter clock is peripheral clock divided per the 4-bit divider code
// [RULE_02] software sets timebase to cycles making at least one microsecond
// [RULE_03] guard delay before conversion after reference or gain change
// [RULE_04] reference code decodes supply, external pin, four internal levels
// [RULE_05] internal reference needs 60 microseconds before use
// [RULE_06] source bit picks accumulated result or latest sample low 16 bits
// [RULE_07] window mode: off, below, above, strictly inside, outside
// [RULE_08] 16-bit low and high thresholds compared with selected value
// [RULE_09] six interrupt enable bits at positions 5 to 0
// [RULE_10] trigger overrun set on start trigger while converting
// [RULE_11] sample overwrite set when unread sample replaced
// [RULE_12] result overwrite set when unread result replaced
// [RULE_13] window match set on completion when condition holds
// [RULE_14] writing one clears a flag, zero leaves it
// [RULE_15] sample ready set on new sample, cleared by sample read
// [RULE_16] result ready set on new result, cleared by result read
// [RULE_17] interrupt is OR of flag and enable pairs
// [RULE_18] reserved window mode never sets window match
module adc_ctrl import adc_ctrl_pkg::*; #(
  parameter int REF_INIT_CYCLES = REF_INIT_CYC
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // register port
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // analog core
  input wire logic START_TRIG,
  input wire logic SAMPLE_DONE,
  input wire logic RESULT_DONE,
  input wire logic [15:0] SAMPLE_IN,
  input wire logic [31:0] RESULT_IN,
  input wire logic GAIN_CHANGED,
  output logic CONV_CLK_EN,
  output logic CONV_START,
  output logic BUSY,
  output logic [2:0] REF_SEL,
  output logic REF_INTERNAL_EN,
  // interrupt
  output logic IRQ
);
  typedef enum {ST_IDLE, ST_GUARD, ST_CONV} state_t;

  adc_div_if dvi ();
  logic [3:0] div_code_r;
  logic [7:0] tref_r, wctl_r, ien_r, flag_r;
  logic [15:0] low_thr_r, high_thr_r, sample_r;
  logic [31:0] result_r;
  logic samp_unread_r, res_unread_r;
  logic [4:0] tb_cnt_r;
  logic us_tick_r;
  logic [15:0] wait_cnt_r;
  logic ref_pending_r, guard_pending_r;
  logic start_req_r;
  state_t st_r;
  logic trig_s1_r, trig_s2_r, trig_s3_r;
  logic sd_s1_r, sd_s2_r, rd_s1_r, rd_s2_r, gc_s1_r, gc_s2_r;

  assign dvi.code = div_code_r;
  adc_clk_div adc_clk_div_i (.clk(CLOCK), .rst_n(RST_N), .dv(dvi));

  // core handshakes come from the analog side, so they are synchronised
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      {trig_s1_r, trig_s2_r, trig_s3_r} <= 3'b000;
      {sd_s1_r, sd_s2_r, rd_s1_r, rd_s2_r, gc_s1_r, gc_s2_r} <= 6'h00;
    end else begin
      {trig_s1_r, trig_s2_r, trig_s3_r} <= {START_TRIG, trig_s1_r, trig_s2_r};
      {sd_s1_r, sd_s2_r} <= {SAMPLE_DONE, sd_s1_r};
      {rd_s1_r, rd_s2_r} <= {RESULT_DONE, rd_s1_r};
      {gc_s1_r, gc_s2_r} <= {GAIN_CHANGED, gc_s1_r};
    end
  end
  wire trig_ev = trig_s2_r & ~trig_s3_r;
  wire samp_ev = sd_s2_r;
  wire res_ev = rd_s2_r;
  // restart the timebase on a trigger so a guard is never shorter than a full microsecond
  wire tb_restart = st_r == ST_IDLE && trig_ev; // [RULE_03]

  // register decode
  wire wr_div = WR && ADDR == OFS_CLOCK_DIV;
  wire wr_tref = WR && ADDR == OFS_TIMING_REF;
  wire wr_wctl = WR && ADDR == OFS_WINDOW_CTRL;
  wire wr_ien = WR && ADDR == OFS_IRQ_ENABLE;
  wire wr_flag = WR && ADDR == OFS_IRQ_FLAG;
  wire rd_res = RD && ADDR == OFS_RESULT;
  wire rd_samp = RD && ADDR == OFS_SAMPLE;
  wire [2:0] ref_code = tref_r[2:0];
  wire [4:0] timebase = tref_r[7:TB_LSB];
  wire ref_wr_change = wr_tref && WDATA[2:0] != ref_code;
  wire ref_to_internal = ref_wr_change && WDATA[2]; // [RULE_04] [RULE_05]

  // window comparator
  wire [2:0] wmode = wctl_r[2:0];
  wire [15:0] w_src = wctl_r[WSRC_BIT] ? SAMPLE_IN : RESULT_IN[15:0]; // [RULE_06]
  wire w_lt = w_src < low_thr_r; // [RULE_08]
  wire w_gt = w_src > high_thr_r; // [RULE_08]
  logic w_hit;
  always_comb begin
    case (wmode) // [RULE_07] [RULE_18]
      WM_BELOW: w_hit = w_lt;
      WM_ABOVE: w_hit = w_gt;
      WM_INSIDE: w_hit = (w_src > low_thr_r) && (w_src < high_thr_r);
      WM_OUTSIDE: w_hit = w_lt || w_gt;
      default: w_hit = 1'b0;
    endcase
  end
  // the compared value is the one landing in the register this cycle
  wire w_event = wctl_r[WSRC_BIT] ? samp_ev : res_ev;

  // flags: set wins over software clear and over read clear
  wire [7:0] flag_set = {2'b00,
    trig_ev && st_r != ST_IDLE, // [RULE_10]
    samp_ev && samp_unread_r, // [RULE_11]
    res_ev && res_unread_r, // [RULE_12]
    w_event && w_hit, // [RULE_13]
    samp_ev, // [RULE_15]
    res_ev}; // [RULE_16]
  wire [7:0] flag_clr = (wr_flag ? WDATA : 8'h00) // [RULE_14]
    | {6'h00, rd_samp, rd_res}; // [RULE_15] [RULE_16]
  wire [7:0] flag_nxt = ((flag_r & ~flag_clr) | flag_set) & 8'h3f;
  wire [7:0] ien_nxt = wr_ien ? {2'b00, WDATA[5:0]} : ien_r; // [RULE_09]

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_code_r <= 4'h0;
      tref_r <= RESET_BYTE;
      wctl_r <= RESET_BYTE;
      ien_r <= RESET_BYTE;
      low_thr_r <= 16'h0000;
      high_thr_r <= 16'h0000;
    end else if (WR) begin
      if (wr_div) div_code_r <= WDATA[3:0];
      if (wr_tref) tref_r <= WDATA;
      if (wr_wctl) wctl_r <= {4'h0, WDATA[3:0]};
      if (wr_ien) ien_r <= ien_nxt; // [RULE_09]
      if (ADDR == OFS_LOW_THR) low_thr_r[7:0] <= WDATA;
      if (ADDR == OFS_LOW_THR + 5'h01) low_thr_r[15:8] <= WDATA;
      if (ADDR == OFS_HIGH_THR) high_thr_r[7:0] <= WDATA;
      if (ADDR == OFS_HIGH_THR + 5'h01) high_thr_r[15:8] <= WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      flag_r <= 8'h00;
      sample_r <= 16'h0000;
      result_r <= 32'h0;
      samp_unread_r <= 1'b0;
      res_unread_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (samp_ev) sample_r <= SAMPLE_IN;
      if (res_ev) result_r <= RESULT_IN;
      samp_unread_r <= samp_ev | (samp_unread_r & ~rd_samp);
      res_unread_r <= res_ev | (res_unread_r & ~rd_res);
    end
  end

  // microsecond timebase: one tick every timebase+1 cycles
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tb_cnt_r <= 5'h00;
      us_tick_r <= 1'b0;
    end else if (tb_restart) begin
      tb_cnt_r <= 5'h00;
      us_tick_r <= 1'b0;
    end else if (tb_cnt_r >= timebase) begin
      tb_cnt_r <= 5'h00;
      us_tick_r <= 1'b1; // [RULE_02]
    end else begin
      tb_cnt_r <= tb_cnt_r + 5'h01;
      us_tick_r <= 1'b0;
    end
  end

  // reference and gain settling, then conversion start
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= ST_IDLE;
      wait_cnt_r <= 16'h0000;
      ref_pending_r <= 1'b0;
      guard_pending_r <= 1'b0;
      start_req_r <= 1'b0;
    end else begin
      start_req_r <= 1'b0;
      if (ref_to_internal) ref_pending_r <= 1'b1; // [RULE_05]
      if (ref_wr_change || gc_s2_r) guard_pending_r <= 1'b1; // [RULE_03]
      case (st_r)
        ST_IDLE: begin
          if (trig_ev) begin
            st_r <= ST_GUARD;
            wait_cnt_r <= ref_pending_r ? 16'(REF_INIT_CYCLES)
                        : guard_pending_r ? 16'(GUARD_US) : 16'h0000;
            ref_pending_r <= 1'b0;
            guard_pending_r <= 1'b0;
          end
        end
        ST_GUARD: begin
          // the internal reference is counted in cycles, the guard in timebase units
          if (wait_cnt_r == 16'h0000) begin
            st_r <= ST_CONV;
            start_req_r <= 1'b1; // [RULE_03] [RULE_05]
          end else if (wait_cnt_r > 16'(GUARD_US) || us_tick_r) begin
            wait_cnt_r <= wait_cnt_r - 16'h0001;
          end
        end
        ST_CONV: if (res_ev) st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // register read mux, data one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    case (ADDR)
      OFS_CLOCK_DIV: rd_mux = {4'h0, div_code_r};
      OFS_TIMING_REF: rd_mux = tref_r;
      OFS_WINDOW_CTRL: rd_mux = wctl_r;
      OFS_IRQ_ENABLE: rd_mux = ien_r;
      OFS_IRQ_FLAG: rd_mux = flag_r;
      OFS_STATUS: rd_mux = {7'h00, st_r != ST_IDLE};
      OFS_RESULT: rd_mux = result_r[7:0];
      OFS_SAMPLE: rd_mux = sample_r[7:0];
      OFS_LOW_THR: rd_mux = low_thr_r[7:0];
      OFS_LOW_THR + 5'h01: rd_mux = low_thr_r[15:8];
      OFS_HIGH_THR: rd_mux = high_thr_r[7:0];
      OFS_HIGH_THR + 5'h01: rd_mux = high_thr_r[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      IRQ <= 1'b0;
      CONV_CLK_EN <= 1'b0;
      CONV_START <= 1'b0;
      BUSY <= 1'b0;
      REF_SEL <= REF_SUPPLY;
      REF_INTERNAL_EN <= 1'b0;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
      IRQ <= |(flag_nxt & ien_nxt); // [RULE_17]
      CONV_CLK_EN <= dvi.tick; // [RULE_01]
      CONV_START <= start_req_r;
      BUSY <= st_r != ST_IDLE;
      REF_SEL <= ref_code; // [RULE_04]
      REF_INTERNAL_EN <= ref_code[2]; // [RULE_04]
    end
  end

  irq_level_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    1'b1 |=> IRQ == |(flag_r & ien_r)) else $error("irq mismatch"); // [RULE_17]
  w1c_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_flag && WDATA[FLG_TRIG_OVR] && !flag_set[FLG_TRIG_OVR] |=> !flag_r[FLG_TRIG_OVR])
    else $error("flag not cleared"); // [RULE_14]
  w0_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_flag && !WDATA[FLG_WMATCH] && flag_r[FLG_WMATCH] |=> flag_r[FLG_WMATCH])
    else $error("flag lost on zero write"); // [RULE_14]
  trig_ovr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    trig_ev && st_r == ST_CONV |=> flag_r[FLG_TRIG_OVR]) else $error("no overrun"); // [RULE_10]
  samp_ovr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    samp_ev && samp_unread_r |=> flag_r[FLG_SAMP_OVR]) else $error("no sample ovr"); // [RULE_11]
  res_ovr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    res_ev && res_unread_r |=> flag_r[FLG_RES_OVR]) else $error("no result ovr"); // [RULE_12]
  win_reserved_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wmode > WM_OUTSIDE |-> !flag_set[FLG_WMATCH]) else $error("reserved mode match"); // [RULE_18]
  win_match_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    res_ev && !wctl_r[WSRC_BIT] && wmode == WM_BELOW && RESULT_IN[15:0] < low_thr_r
    |=> flag_r[FLG_WMATCH]) else $error("below match missed"); // [RULE_13]
  samp_rdy_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    rd_samp && !samp_ev |=> !flag_r[FLG_SAMP_RDY]) else $error("read clear failed"); // [RULE_15]
  res_rdy_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    res_ev |=> flag_r[FLG_RES_RDY]) else $error("result ready missed"); // [RULE_16]
  guard_start_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st_r == ST_GUARD && wait_cnt_r != 16'h0000 |=> !start_req_r)
    else $error("start before delay"); // [RULE_03]
  ref_init_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st_r == ST_IDLE && trig_ev && ref_pending_r |=> st_r == ST_GUARD ##1 !start_req_r)
    else $error("internal reference not waited"); // [RULE_05]
endmodule : adc_ctrl
`default_nettype wire

// ==== adc_ctrl_pkg.sv ====
// constants for the converter control block
package adc_ctrl_pkg;
  localparam logic [4:0] OFS_CLOCK_DIV = 5'h01;
  localparam logic [4:0] OFS_TIMING_REF = 5'h02;
  localparam logic [4:0] OFS_WINDOW_CTRL = 5'h03;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h04;
  localparam logic [4:0] OFS_IRQ_FLAG = 5'h05;
  localparam logic [4:0] OFS_STATUS = 5'h06;
  localparam logic [4:0] OFS_RESULT = 5'h10;
  localparam logic [4:0] OFS_SAMPLE = 5'h14;
  localparam logic [4:0] OFS_LOW_THR = 5'h1c;
  localparam logic [4:0] OFS_HIGH_THR = 5'h1e;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int TB_LSB = 3;
  localparam int WSRC_BIT = 3;
  localparam int FLG_TRIG_OVR = 5;
  localparam int FLG_SAMP_OVR = 4;
  localparam int FLG_RES_OVR = 3;
  localparam int FLG_WMATCH = 2;
  localparam int FLG_SAMP_RDY = 1;
  localparam int FLG_RES_RDY = 0;
  localparam logic [2:0] REF_SUPPLY = 3'h0;
  localparam logic [2:0] REF_EXT_PIN = 3'h2;
  localparam logic [2:0] WM_OFF = 3'h0;
  localparam logic [2:0] WM_BELOW = 3'h1;
  localparam logic [2:0] WM_ABOVE = 3'h2;
  localparam logic [2:0] WM_INSIDE = 3'h3;
  localparam logic [2:0] WM_OUTSIDE = 3'h4;
  localparam int CLK_MHZ = 100;
  localparam int REF_INIT_US = 60;
  localparam int GUARD_US = 1;
  localparam int REF_INIT_CYC = REF_INIT_US * CLK_MHZ;
endpackage : adc_ctrl_pkg

// ==== adc_div_if.sv ====
// divider code and pulse carried between controller and divider
`timescale 1ns/1ps
`default_nettype none
interface adc_div_if;
  logic [3:0] code;
  logic tick;
  modport ctrl (output code, input tick);
  modport div (input code, output tick);
endinterface : adc_div_if
`default_nettype wire

// ==== adc_clk_div.sv ====
// converter clock enable divider
`timescale 1ns/1ps
`default_nettype none
module adc_clk_div (
  input wire logic clk,
  input wire logic rst_n,
  adc_div_if.div dv
);
  logic [6:0] cnt_r;
  wire [6:0] ratio;

  function automatic logic [6:0] div_ratio(input logic [3:0] c);
    if (c < 4'h8) div_ratio = {2'b00, c, 1'b0} + 7'h02;
    else if (c < 4'hc) div_ratio = {1'b0, c[1:0], 2'b00} + 7'h14;
    else div_ratio = {c[1:0], 3'b000} + 7'h28;
  endfunction : div_ratio

  assign ratio = div_ratio(dv.code); // [RULE_01]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 7'h00;
      dv.tick <= 1'b0;
    end else if (cnt_r + 7'h01 >= ratio) begin
      cnt_r <= 7'h00;
      dv.tick <= 1'b1; // [RULE_01]
    end else begin
      cnt_r <= cnt_r + 7'h01;
      dv.tick <= 1'b0;
    end
  end

  tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dv.tick) && dv.code == 4'h0 ##1 dv.code == 4'h0 |-> !dv.tick ##1 dv.tick)
    else $error("divide by two period wrong"); // [RULE_01]
endmodule : adc_clk_div
`default_nettype wire

// ==== adc_core_model.sv ====
// behavioural model of the analog conversion core
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // start request and value to convert
  input wire logic start,
  input wire logic [15:0] value,
  // conversion answers
  output logic sample_done,
  output logic result_done,
  output logic [15:0] sample_in,
  output logic [31:0] result_in
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      sample_done <= 1'b0;
      result_done <= 1'b0;
      sample_in <= 16'h0000;
      result_in <= 32'h0000_0000;
    end else begin
      // fixed length keeps a second trigger inside the conversion
      cnt_r <= start ? 4'hc : cnt_r - {3'h0, cnt_r != 4'h0};
      sample_done <= cnt_r == 4'h1;
      result_done <= cnt_r == 4'h1;
      if (cnt_r == 4'h1) begin
        // data held until the next completion, far beyond the hold need
        sample_in <= value;
        result_in <= {16'h0001, value ^ 16'h0001};
      end
    end
  end
endmodule : adc_core_model
`default_nettype wire

// ==== adc_clock_reference_window_irq_test.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_clock_reference_window_irq_test import adc_ctrl_pkg::*; ;
  localparam int INIT = 80;
  logic CLOCK, RST_N, WR, RD, START_TRIG, GAIN_CHANGED, SAMPLE_DONE, RESULT_DONE;
  logic CONV_CLK_EN, CONV_START, BUSY, REF_INTERNAL_EN, IRQ;
  logic [4:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic [2:0] REF_SEL;
  logic [15:0] SAMPLE_IN, val;
  logic [31:0] RESULT_IN;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  adc_ctrl #(.REF_INIT_CYCLES(INIT)) adc_ctrl_i (.CLOCK, .RST_N, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .START_TRIG, .SAMPLE_DONE, .RESULT_DONE, .SAMPLE_IN, .RESULT_IN, .GAIN_CHANGED,
    .CONV_CLK_EN, .CONV_START, .BUSY, .REF_SEL, .REF_INTERNAL_EN, .IRQ);
  adc_core_model adc_core_model_i (.clk(CLOCK), .rst_n(RST_N), .start(CONV_START),
    .value(val), .sample_done(SAMPLE_DONE), .result_done(RESULT_DONE),
    .sample_in(SAMPLE_IN), .result_in(RESULT_IN));
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // one strobe cycle; read data is taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= w;
    RD <= !w;
    @(posedge CLOCK);
    WR <= 1'b0;
    RD <= 1'b0;
    #1 v = RDATA;
  endtask : bus
  // n counts cycles from trigger to conversion start
  task automatic conv(input logic [15:0] v, input logic ovr, output int n);
    n = 0;
    @(posedge CLOCK);
    val <= v;
    START_TRIG <= 1'b1;
    do begin
      @(posedge CLOCK);
      #1 n = n + 1;
    end while (CONV_START !== 1'b1 && n < 300);
    check(BUSY, 1'b1);
    @(posedge CLOCK);
    START_TRIG <= 1'b0;
    if (ovr) begin
      repeat (2) @(posedge CLOCK);
      START_TRIG <= 1'b1;
      repeat (2) @(posedge CLOCK);
      START_TRIG <= 1'b0;
    end
    #1;
    for (int i = 0; i < 99 && BUSY === 1'b1; i++) #10;
    repeat (5) @(posedge CLOCK);
  endtask : conv
  function automatic logic wexp(input logic [2:0] m, input logic [15:0] o);
    case (m)
      3'h1: return o < 16'h0100;
      3'h2: return o > 16'h0200;
      3'h3: return o > 16'h0100 && o < 16'h0200;
      3'h4: return o < 16'h0100 || o > 16'h0200;
      default: return 1'b0;
    endcase
  endfunction : wexp
  task automatic t_regs;
    logic [7:0] v;
    for (int a = 2; a < 6; a++) begin
      bus(1'b0, a[4:0], 8'h00, v);
      check(v, RESET_BYTE);
    end
    bus(1'b1, OFS_WINDOW_CTRL, 8'h0c, v);
    bus(1'b0, OFS_WINDOW_CTRL, 8'h00, v);
    check(v, 8'h0c);
    bus(1'b1, OFS_IRQ_ENABLE, 8'h3f, v);
    bus(1'b0, OFS_IRQ_ENABLE, 8'h00, v);
    check(v, 8'h3f);
    bus(1'b0, 5'h0e, 8'h00, v);
    check(v, 8'h00);
    bus(1'b1, OFS_IRQ_ENABLE, 8'h00, v);
  endtask : t_regs
  task automatic t_div;
    int n;
    logic [7:0] v;
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, OFS_CLOCK_DIV, 8'(c), v);
      // the first gap may straddle the code change
      repeat (3) begin
        n = 0;
        do begin
          @(posedge CLOCK);
          #1 n = n + 1;
        end while (CONV_CLK_EN !== 1'b1 && n < 100);
      end
      check(n, c < 8 ? 2 * c + 2 : (c < 12 ? 4 * c - 12 : 8 * c - 56));
    end
  endtask : t_div
  task automatic t_ref;
    logic [7:0] v;
    int n;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFS_TIMING_REF, {5'h1f, c[2:0]}, v);
      #10;
      check(REF_SEL, c[2:0]);
      check(REF_INTERNAL_EN, c[2]);
    end
    bus(1'b1, OFS_TIMING_REF, 8'hf8, v);
    conv(16'h0000, 1'b0, n);
    conv(16'h0000, 1'b0, n);
    check(n < 31, 1'b1);
    GAIN_CHANGED <= 1'b1;
    @(posedge CLOCK);
    GAIN_CHANGED <= 1'b0;
    conv(16'h0000, 1'b0, n);
    check(n >= 31, 1'b1);
    bus(1'b1, OFS_TIMING_REF, 8'hfc, v);
    conv(16'h0000, 1'b0, n);
    check(n >= INIT, 1'b1);
    bus(1'b1, OFS_TIMING_REF, 8'hf8, v);
  endtask : t_ref
  task automatic t_window;
    logic [15:0] vals [5] = '{16'h00ff, 16'h0100, 16'h0150, 16'h0200, 16'h0201};
    logic [7:0] v;
    int n;
    bus(1'b1, OFS_LOW_THR, 8'h00, v);
    bus(1'b1, OFS_LOW_THR + 5'h01, 8'h01, v);
    bus(1'b1, OFS_HIGH_THR, 8'h00, v);
    bus(1'b1, OFS_HIGH_THR + 5'h01, 8'h02, v);
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 8; m++) begin
        for (int k = 0; k < 5; k++) begin
          bus(1'b1, OFS_WINDOW_CTRL, {4'h0, s[0], m[2:0]}, v);
          bus(1'b1, OFS_IRQ_FLAG, 8'h3f, v);
          conv(vals[k], 1'b0, n);
          bus(1'b0, OFS_IRQ_FLAG, 8'h00, v);
          check(v[FLG_WMATCH], wexp(m[2:0], vals[k] ^ {15'h0, !s[0]}));
        end
      end
    end
  endtask : t_window
  task automatic t_flags;
    logic [7:0] v;
    int n;
    bus(1'b0, OFS_RESULT, 8'h00, v);
    bus(1'b0, OFS_SAMPLE, 8'h00, v);
    bus(1'b1, OFS_WINDOW_CTRL, 8'h00, v);
    bus(1'b1, OFS_IRQ_FLAG, 8'h3f, v);
    conv(16'h1234, 1'b0, n);
    bus(1'b0, OFS_IRQ_FLAG, 8'h00, v);
    check(v, 8'h03);
    bus(1'b0, OFS_SAMPLE, 8'h00, v);
    check(v, 8'h34);
    bus(1'b0, OFS_IRQ_FLAG, 8'h00, v);
    check(v, 8'h01);
    conv(16'h1234, 1'b0, n);
    bus(1'b0, OFS_RESULT, 8'h00, v);
    check(v, 8'h35);
    bus(1'b0, OFS_IRQ_FLAG, 8'h00, v);
    check(v, 8'h0a);
    bus(1'b1, OFS_IRQ_FLAG, 8'h08, v);
    bus(1'b1, OFS_IRQ_FLAG, 8'h00, v);
    bus(1'b0, OFS_IRQ_FLAG, 8'h00, v);
    check(v, 8'h02);
    bus(1'b0, OFS_STATUS, 8'h00, v);
    check(v, 8'h00);
    conv(16'h1234, 1'b0, n);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFS_IRQ_ENABLE, 8'h01 << i, v);
      #10;
      check(IRQ, (8'h13 >> i) & 8'h01);
    end
    conv(16'h0000, 1'b1, n);
    bus(1'b0, OFS_IRQ_FLAG, 8'h00, v);
    check(v[FLG_TRIG_OVR], 1'b1);
    check(IRQ, 1'b1);
    bus(1'b1, OFS_IRQ_FLAG, 8'h20, v);
    #10;
    check(IRQ, 1'b0);
  endtask : t_flags
  initial begin
    RST_N = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 5'h00;
    WDATA = 8'h00;
    START_TRIG = 1'b0;
    GAIN_CHANGED = 1'b0;
    val = 16'h0000;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_regs();
    t_div();
    t_ref();
    t_window();
    t_flags();
    close_out();
  end
endmodule : adc_clock_reference_window_irq_test
`default_nettype wire
